// ---- dco_offset_down.sv ----
module dco_offset_down
    import dco_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // Register port, already deserialised
    input wire logic i_reg_valid,
    input wire logic [7:0] i_reg_opcode,
    input wire logic [15:0] i_reg_wdata,
    output logic o_reg_rvalid,
    output logic [15:0] o_reg_rdata,
    // Measurement control
    input wire logic i_edge_polarity_select,
    input wire logic i_measure_start,
    input wire logic i_comparator_hit,
    // Threshold to the comparator DAC
    output logic [DCO_CODE_W-1:0] o_threshold_code,
    output logic o_return_phase
);
    initial begin
        if (DCO_SYNC_STAGES != 2) begin
            $error("dco_offset_down: synchroniser depth must be 2");
        end
        if (DCO_FULL_SCALE != 12'hc00) begin
            $error("dco_offset_down: full scale must be 3072");
        end
    end

    logic [15:0] offset_reg, offset_next;
    logic rvalid_reg, rvalid_next;
    logic [15:0] rdata_reg, rdata_next;
    dco_phase_t phase_reg, phase_next;
    logic [DCO_CODE_W-1:0] code_reg, code_next;
    logic sync1_reg, sync2_reg, sync3_reg;
    logic hit_pulse;
    logic [DCO_CODE_W-1:0] calc_code;

    // Opcode decode shared by the port logic and its checks
    function automatic logic dco_is_op(input logic valid,
                                       input logic [7:0] opcode,
                                       input logic [7:0] match);
        return valid && opcode == match;
    endfunction : dco_is_op

    // Register port
    always_comb begin
        offset_next = offset_reg;
        rvalid_next = 1'b0;
        rdata_next = rdata_reg;
        if (dco_is_op(i_reg_valid, i_reg_opcode, DCO_OP_WRITE)) begin
            // Reserved bit 7 is not stored and reads back zero
            offset_next = i_reg_wdata & DCO_WRITE_MASK;
        end
        if (dco_is_op(i_reg_valid, i_reg_opcode, DCO_OP_READ)) begin
            rvalid_next = 1'b1;
            rdata_next = offset_reg;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            offset_reg <= DCO_REG_RESET;
            rvalid_reg <= 1'b0;
            rdata_reg <= DCO_REG_RESET;
        end else begin
            offset_reg <= offset_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
        end
    end

    // Comparator output is asynchronous to the device clock
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
        end else begin
            sync1_reg <= i_comparator_hit;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    assign hit_pulse = sync2_reg && !sync3_reg;

    // Threshold phase
    always_comb begin
        phase_next = phase_reg;
        unique case (phase_reg)
            DCO_SEARCH: begin
                if (hit_pulse) begin
                    phase_next = DCO_RETURN;
                end
            end
            DCO_RETURN: begin
                phase_next = DCO_RETURN;
            end
        endcase
        // A new measurement always re-arms the early-edge search
        if (i_measure_start) begin
            phase_next = DCO_SEARCH;
        end
    end

    dco_threshold_calc u_calc (
        .i_edge_polarity_select(i_edge_polarity_select),
        .i_return_phase(phase_reg == DCO_RETURN),
        .i_initial_offset_down(offset_reg[DCO_INIT_MSB:DCO_INIT_LSB]),
        .i_return_offset_down(offset_reg[DCO_RET_MSB:DCO_RET_LSB]),
        .o_code(calc_code)
    );

    always_comb begin
        code_next = calc_code;
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            phase_reg <= DCO_SEARCH;
            code_reg <= DCO_CODE_RESET;
        end else begin
            phase_reg <= phase_next;
            code_reg <= code_next;
        end
    end

    assign o_reg_rvalid = rvalid_reg;
    assign o_reg_rdata = rdata_reg;
    assign o_threshold_code = code_reg;
    assign o_return_phase = (phase_reg == DCO_RETURN);

    // Checks share the device clock and pause while reset is held
    default clocking dco_cb @(posedge i_clock);
    endclocking

    default disable iff (i_sys_rst);

    reg_write_a: assert property (
        dco_is_op(i_reg_valid, i_reg_opcode, DCO_OP_WRITE)
        |=> offset_reg == ($past(i_reg_wdata) & DCO_WRITE_MASK))
        else $error("write did not update offset register");

    // Foreign opcodes and idle cycles must leave the offset alone
    reg_keep_a: assert property (
        !dco_is_op(i_reg_valid, i_reg_opcode, DCO_OP_WRITE)
        |=> offset_reg == $past(offset_reg))
        else $error("offset register changed without a write");

    reg_read_a: assert property (
        dco_is_op(i_reg_valid, i_reg_opcode, DCO_OP_READ)
        |=> o_reg_rvalid && o_reg_rdata == $past(offset_reg))
        else $error("read answer wrong or missing");

    read_only_a: assert property (
        !dco_is_op(i_reg_valid, i_reg_opcode, DCO_OP_READ)
        |=> !o_reg_rvalid && o_reg_rdata == $past(o_reg_rdata))
        else $error("read answer without a read");

    rise_code_a: assert property (
        phase_reg == DCO_SEARCH && !i_edge_polarity_select
        |=> o_threshold_code == DCO_RISE_BIAS
            + {5'h00, $past(offset_reg[DCO_INIT_MSB:DCO_INIT_LSB])})
        else $error("rising threshold code wrong");

    fall_code_a: assert property (
        phase_reg == DCO_SEARCH && i_edge_polarity_select
        |=> o_threshold_code == DCO_FALL_BIAS
            - {5'h00, $past(offset_reg[DCO_INIT_MSB:DCO_INIT_LSB])})
        else $error("falling threshold code wrong");

    rise_above_a: assert property (
        phase_reg == DCO_SEARCH && !i_edge_polarity_select
        |=> o_threshold_code >= DCO_RISE_BIAS)
        else $error("rising threshold below zero crossing");

    fall_below_a: assert property (
        phase_reg == DCO_SEARCH && i_edge_polarity_select
        |=> o_threshold_code <= DCO_FALL_BIAS)
        else $error("falling threshold above zero crossing");

    return_code_a: assert property (
        phase_reg == DCO_RETURN
        |=> o_threshold_code == DCO_RET_BIAS
            + {{4{$past(offset_reg[DCO_RET_MSB])}},
               $past(offset_reg[DCO_RET_MSB:DCO_RET_LSB])})
        else $error("return threshold code wrong");

    hit_switch_a: assert property (
        phase_reg == DCO_SEARCH && $rose(sync2_reg) && !i_measure_start
        |=> o_return_phase ##1 o_threshold_code == DCO_RET_BIAS
            + {{4{$past(offset_reg[DCO_RET_MSB])}},
               $past(offset_reg[DCO_RET_MSB:DCO_RET_LSB])})
        else $error("early edge did not switch to return offset");

    // Only a fresh comparator edge may leave the search phase
    search_hold_a: assert property (
        !o_return_phase && !$rose(sync2_reg)
        |=> !o_return_phase)
        else $error("left search without an early edge");

    // Later comparator edges must not disturb the return offset
    return_hold_a: assert property (
        o_return_phase && !i_measure_start
        |=> o_return_phase)
        else $error("return phase dropped without a start");

    rearm_a: assert property (
        i_measure_start |=> !o_return_phase)
        else $error("measurement start did not re-arm search");

    pol_select_a: assert property (
        phase_reg == DCO_SEARCH && offset_reg[6:0] == 7'h00
        |=> o_threshold_code == ($past(i_edge_polarity_select)
            ? DCO_FALL_BIAS : DCO_RISE_BIAS))
        else $error("polarity select inverted");
endmodule : dco_offset_down

// ---- dco_pkg.sv ----
package dco_pkg;
    // Serial register port opcodes
    localparam logic [7:0] DCO_OP_WRITE = 8'h3e;
    localparam logic [7:0] DCO_OP_READ = 8'hbe;

    // Register layout
    localparam logic [15:0] DCO_REG_RESET = 16'h0000;
    localparam logic [15:0] DCO_WRITE_MASK = 16'hff7f;
    localparam int DCO_INIT_LSB = 0;
    localparam int DCO_INIT_MSB = 6;
    localparam int DCO_RET_LSB = 8;
    localparam int DCO_RET_MSB = 15;
    localparam int DCO_INIT_W = 7;
    localparam int DCO_RET_W = 8;

    // Threshold code scale
    localparam int DCO_CODE_W = 12;
    localparam logic [11:0] DCO_FULL_SCALE = 12'hc00;
    localparam logic [11:0] DCO_RISE_BIAS = 12'h480;
    localparam logic [11:0] DCO_FALL_BIAS = 12'h47f;
    localparam logic [11:0] DCO_RET_BIAS = 12'h480;
    localparam logic [11:0] DCO_CODE_RESET = 12'h480;

    // Comparator event synchroniser depth
    localparam int DCO_SYNC_STAGES = 2;

    typedef enum logic {
        DCO_SEARCH,
        DCO_RETURN
    } dco_phase_t;
endpackage : dco_pkg

// ---- dco_threshold_calc.sv ----
module dco_threshold_calc
    import dco_pkg::*;
(
    // Selection
    input wire logic i_edge_polarity_select,
    input wire logic i_return_phase,
    // Offset fields
    input wire logic [DCO_INIT_W-1:0] i_initial_offset_down,
    input wire logic [DCO_RET_W-1:0] i_return_offset_down,
    // Result
    output logic [DCO_CODE_W-1:0] o_code
);
    logic [DCO_CODE_W-1:0] init_ext;
    logic [DCO_CODE_W-1:0] ret_ext;

    always_comb begin
        init_ext = {{(DCO_CODE_W-DCO_INIT_W){1'b0}}, i_initial_offset_down};
        ret_ext = {{(DCO_CODE_W-DCO_RET_W){i_return_offset_down[7]}},
                   i_return_offset_down};
        if (i_return_phase) begin
            o_code = DCO_RET_BIAS + ret_ext;
        end else if (i_edge_polarity_select) begin
            o_code = DCO_FALL_BIAS - init_ext;
        end else begin
            o_code = DCO_RISE_BIAS + init_ext;
        end
    end
endmodule : dco_threshold_calc

// ---- dco_host_model.sv ----
module dco_host_model
    import dco_pkg::*;
(
    // Clock
    input wire logic i_clock,
    // Register port
    output logic o_reg_valid,
    output logic [7:0] o_reg_opcode,
    output logic [15:0] o_reg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_reg_valid = 1'b0;
        o_reg_opcode = 8'h00;
        o_reg_wdata = 16'h0000;
    end

    // Idle bus shows inverted words, so stale data never passes as fresh
    task automatic send(input logic [7:0] op, input logic [15:0] d);
        @(posedge i_clock);
        o_reg_valid <= 1'b1;
        o_reg_opcode <= op;
        o_reg_wdata <= d;
        @(posedge i_clock);
        o_reg_valid <= 1'b0;
        o_reg_opcode <= ~op;
        o_reg_wdata <= ~d;
    endtask : send
endmodule : dco_host_model

// ---- tb_downstream_comparator_offset.sv ----
`define CHK(nm, ex, got) check_count++; if ((got) !== (ex)) begin \
    n_fail++; $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end
module tb_downstream_comparator_offset
    import dco_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock = 1'b0;
    logic i_sys_rst = 1'b1;
    logic pol = 1'b0;
    logic start = 1'b0;
    logic hit = 1'b0;
    logic reg_valid, rvalid, ret, p;
    logic [7:0] opcode;
    logic [15:0] wdata, rdata, reg_val, exp_r, w;
    logic [11:0] code;
    logic [15:0] exp_q[$];
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;

    always #2 i_clock = ~i_clock;

    dco_host_model host (.i_clock(i_clock), .o_reg_valid(reg_valid),
        .o_reg_opcode(opcode), .o_reg_wdata(wdata));
    dco_offset_down dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
        .i_reg_valid(reg_valid), .i_reg_opcode(opcode),
        .i_reg_wdata(wdata), .o_reg_rvalid(rvalid), .o_reg_rdata(rdata),
        .i_edge_polarity_select(pol), .i_measure_start(start),
        .i_comparator_hit(hit), .o_threshold_code(code),
        .o_return_phase(ret));

    task tally_and_finish;
        if (n_fail == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    function automatic logic [11:0] search_code(input logic s,
                                                input logic [15:0] r);
        return s ? DCO_FALL_BIAS - 12'(r[6:0]) : DCO_RISE_BIAS + 12'(r[6:0]);
    endfunction : search_code

    function automatic logic [11:0] ret_code(input logic [15:0] r);
        return DCO_RET_BIAS + {{4{r[15]}}, r[15:8]};
    endfunction : ret_code

    task wr(input logic [15:0] d);
        host.send(DCO_OP_WRITE, d);
        reg_val = d & DCO_WRITE_MASK;
    endtask : wr

    task rd;
        exp_q.push_back(reg_val);
        host.send(DCO_OP_READ, 16'h0000);
        @(posedge i_clock);
    endtask : rd

    task chk_code(input logic [11:0] e);
        repeat (5) @(posedge i_clock);
        @(negedge i_clock);
        `CHK("threshold", e, code)
    endtask : chk_code

    // Cut a hang short well past the expected run length
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    always @(negedge i_clock) begin
        if (rvalid === 1'b1) begin
            exp_r = exp_q.size() > 0 ? exp_q.pop_front() : ~rdata;
            `CHK("rdata", exp_r, rdata)
        end
    end

    initial begin
        void'($urandom(32'h27dd));
        reg_val = 16'h0000;
        repeat (16) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        rd();
        chk_code(DCO_RISE_BIAS);
        for (int k = 0; k < 8; k++) begin
            w = k == 0 ? 16'h007f : (k == 1 ? 16'hff80 : 16'($urandom));
            p = k < 2 ? k[0] : 1'($urandom);
            @(posedge i_clock);
            pol <= p;
            wr(w);
            rd();
            chk_code(search_code(p, reg_val));
        end
        // Foreign opcode must leave the register alone
        host.send(8'h3f, 16'hffff);
        rd();
        @(posedge i_clock);
        start <= 1'b1;
        @(posedge i_clock);
        start <= 1'b0;
        hit <= 1'b1;
        chk_code(ret_code(reg_val));
        `CHK("phase", 1'b1, ret)
        @(posedge i_clock);
        pol <= ~pol;
        hit <= 1'b0;
        chk_code(ret_code(reg_val));
        @(posedge i_clock);
        hit <= 1'b1;
        chk_code(ret_code(reg_val));
        @(posedge i_clock);
        hit <= 1'b0;
        start <= 1'b1;
        @(posedge i_clock);
        start <= 1'b0;
        chk_code(search_code(pol, reg_val));
        `CHK("phase", 1'b0, ret)
        // Start and early edge in one cycle: start wins
        @(posedge i_clock);
        hit <= 1'b1;
        repeat (2) @(posedge i_clock);
        start <= 1'b1;
        @(posedge i_clock);
        start <= 1'b0;
        hit <= 1'b0;
        chk_code(search_code(pol, reg_val));
        `CHK("phase", 1'b0, ret)
        @(posedge i_clock);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        reg_val = DCO_REG_RESET;
        rd();
        chk_code(search_code(pol, reg_val));
        `CHK("pending", 0, exp_q.size())
        tally_and_finish();
    end
endmodule : tb_downstream_comparator_offset
